/* File: design/rtc_watchdog_timer.sv */
/*
 * Watchdog register block with APB slave, interrupt pin driver and
 * maskable status interrupt; instantiates the watchdog counter.
 * Assumes an APB master on the same clock; interrupt pin resolved outside.
 */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
//
// Overview of operation
// - strobe write reloads and restarts timeout
// - strobe bit clears itself after reload
// - strobe bit always reads back zero
// - lock set keeps timeout field unchanged
// - timeout field writable only while unlocked
// - unlock must precede timeout write
// - interval is field times 31.25 ms
// - settings span 1 to 3Fh
// - field zero disables the watchdog
// - enable set: expiry drives pin, sets flag
// - enable clear: expiry sets flag only
// - polarity selects push-pull high or open-drain low
module rtc_watchdog_timer #(
   parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES,
   parameter int ADDR_W      = 19
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              srst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   // interrupts
   output      logic              irq,
   output      logic              int_out,
   output      logic              int_oe
);

   wdt_if wd ();

   // register state
   logic [5:0] multiplier;
   logic       lock;
   logic       strobe;
   logic [5:0] int_ctl;
   logic       flag;
   logic       pin_hold;
   logic       mask;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [16:0] idx);
      hit = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'b00);
   endfunction : hit

   // decode
   wire        hit_int   = hit(paddr, wdt_pkg::IDX_INT_CTL);
   wire        hit_wdog  = hit(paddr, wdt_pkg::IDX_WDOG);
   wire        hit_stat  = hit(paddr, wdt_pkg::IDX_STATUS);
   wire        hit_mask  = hit(paddr, wdt_pkg::IDX_MASK);
   wire        mapped    = hit_int || hit_wdog || hit_stat || hit_mask;
   wire        setup     = psel && !penable && !pready;
   wire        access    = psel && penable && pready;
   wire        wr_lane0  = access && pwrite && pstrb[0] && !pslverr;
   wire        wr_int    = wr_lane0 && hit_int;
   wire        wr_wdog   = wr_lane0 && hit_wdog;
   wire        wr_stat   = wr_lane0 && hit_stat;
   wire        wr_mask   = wr_lane0 && hit_mask;

   // fields
   wire        watchdog_irq_enable = int_ctl[wdt_pkg::IRQ_EN_BIT - wdt_pkg::INT_LO_BIT];
   wire        pol_high  = int_ctl[wdt_pkg::POL_BIT - wdt_pkg::INT_LO_BIT];
   wire        clr_flag  = wr_stat && pwdata[wdt_pkg::FLAG_BIT];
   wire        next_flag = wd.expire || (flag && !clr_flag);
   wire        next_pin  = (wd.expire && watchdog_irq_enable) || (pin_hold && !clr_flag);

   // read data, strobe position always zero
   wire [7:0]  rd_wdog   = {1'b0, lock, multiplier};
   wire [7:0]  rd_int    = {int_ctl, 2'b00};
   wire [31:0] rd_stat   = {18'h00000, wd.elapsed, 7'h00, flag};
   wire [31:0] rd_data   = hit_wdog ? {24'h000000, rd_wdog} :
                           hit_int  ? {24'h000000, rd_int}  :
                           hit_stat ? rd_stat               :
                           hit_mask ? {31'h00000000, mask}  : 32'h00000000;

   // apb: one wait-free access phase after every setup
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite) ? rd_data : 32'h00000000;
      end
   end

   // timeout field and lock; old lock value gates the field
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         multiplier <= wdt_pkg::MULT_RST;
         lock       <= wdt_pkg::LOCK_RST;
      end
      else if (wr_wdog)
      begin
         lock <= pwdata[wdt_pkg::LOCK_BIT];
         if (!lock)
            multiplier <= pwdata[wdt_pkg::MULT_W-1:0];
      end
   end

   // strobe lives one cycle: the counter reloads on it, then it drops
   always_ff @(posedge clock)
   begin
      if (srst)
         strobe <= 1'b0;
      else
         strobe <= wr_wdog && pwdata[wdt_pkg::STROBE_BIT];
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         int_ctl <= wdt_pkg::INT_CTL_RST;
         mask    <= wdt_pkg::MASK_RST;
      end
      else
      begin
         if (wr_int)
            int_ctl <= pwdata[7:wdt_pkg::INT_LO_BIT];
         if (wr_mask)
            mask <= pwdata[wdt_pkg::FLAG_BIT];
      end
   end

   // expiry wins over a same-cycle clear
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         flag     <= 1'b0;
         pin_hold <= 1'b0;
      end
      else
      begin
         flag     <= next_flag;
         pin_hold <= next_pin;
      end
   end

   // pin driver; open-drain releases by dropping the enable
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         int_out <= 1'b0;
         int_oe  <= 1'b0;
         irq     <= 1'b0;
      end
      else
      begin
         int_out <= pol_high && pin_hold;
         int_oe  <= pol_high || pin_hold;
         irq     <= flag && mask;
      end
   end

   assign wd.reload     = strobe;
   assign wd.multiplier = multiplier;

   wdt_counter #(
      .TICK_CYCLES (TICK_CYCLES)
   ) counter (
      .clock (clock),
      .srst  (srst),
      .wd    (wd)
   );

   // checks
   sequence seq_strobe_write;
      wr_wdog && pwdata[wdt_pkg::STROBE_BIT];
   endsequence

   sequence seq_reload_then_clear;
      strobe ##1 !strobe;
   endsequence

   sequence seq_locked_write;
      wr_wdog && lock;
   endsequence

   AST_STROBE_RELOADS: assert property (@(posedge clock) disable iff (srst)
      seq_strobe_write |=> wd.reload)
      else $error("strobe write did not reload the counter");

   AST_STROBE_SELF_CLEARS: assert property (@(posedge clock) disable iff (srst)
      seq_strobe_write |=> seq_reload_then_clear)
      else $error("strobe did not clear itself");

   AST_STROBE_READS_ZERO: assert property (@(posedge clock) disable iff (srst)
      (pready && !pwrite && hit_wdog) |-> !prdata[wdt_pkg::STROBE_BIT])
      else $error("strobe position read back nonzero");

   AST_LOCK_KEEPS_FIELD: assert property (@(posedge clock) disable iff (srst)
      seq_locked_write |=> $stable(multiplier))
      else $error("timeout field changed while locked");

   AST_UNLOCKED_WRITE: assert property (@(posedge clock) disable iff (srst)
      (wr_wdog && !lock) |=> (multiplier == $past(pwdata[5:0])))
      else $error("unlocked write did not load the timeout field");

   AST_UNLOCK_SAME_CYCLE: assert property (@(posedge clock) disable iff (srst)
      (wr_wdog && lock && !pwdata[wdt_pkg::LOCK_BIT]) |=> $stable(multiplier) && !lock)
      else $error("timeout field loaded in the unlocking write");

   AST_EXPIRE_WITH_ENABLE: assert property (@(posedge clock) disable iff (srst)
      (wd.expire && watchdog_irq_enable) |=> flag && pin_hold ##1 (int_oe || int_out))
      else $error("enabled expiry did not drive the pin");

   AST_EXPIRE_FLAG_ONLY: assert property (@(posedge clock) disable iff (srst)
      (wd.expire && !watchdog_irq_enable && !pin_hold) |=> flag && !pin_hold)
      else $error("disabled expiry touched the pin");

   AST_PIN_POLARITY: assert property (@(posedge clock) disable iff (srst)
      ##1 (int_oe == ($past(pol_high) || $past(pin_hold)))
          && (int_out == ($past(pol_high) && $past(pin_hold))))
      else $error("pin drive does not follow the polarity bit");

   AST_FLAG_SET_WINS: assert property (@(posedge clock) disable iff (srst)
      (wd.expire && clr_flag) |=> flag)
      else $error("expiry lost against a same-cycle clear");

   AST_IRQ_GATED: assert property (@(posedge clock) disable iff (srst)
      ##1 (irq == ($past(flag) && $past(mask))))
      else $error("irq does not follow flag and mask");

   AST_APB_ONE_WAIT: assert property (@(posedge clock) disable iff (srst)
      setup |=> pready ##1 !pready)
      else $error("apb answer not in the access cycle");

endmodule : rtc_watchdog_timer

/* File: inc/wdt_pkg.sv */
/*
 * Constants for the real-time-clock watchdog block: register indexes,
 * field positions, values after reset and time-base figures.
 * Assumes a 250 MHz system clock and 32-bit APB access, one word per register.
 */
package wdt_pkg;

   // register indexes; byte address is four times the index
   localparam logic [16:0] IDX_INT_CTL  = 17'h1fff6;
   localparam logic [16:0] IDX_WDOG     = 17'h1fff7;
   localparam logic [16:0] IDX_STATUS   = 17'h1fff0;
   localparam logic [16:0] IDX_MASK     = 17'h1fff1;

   // watchdog_control fields
   localparam int STROBE_BIT = 7;
   localparam int LOCK_BIT   = 6;
   localparam int MULT_W     = 6;

   // interrupt_control fields, bits 7 down to 2 are stored
   localparam int IRQ_EN_BIT = 7;
   localparam int POL_BIT    = 3;
   localparam int INT_LO_BIT = 2;

   // status and mask fields
   localparam int FLAG_BIT    = 0;
   localparam int ELAPSED_LSB = 8;

   // values after reset
   localparam logic [5:0] MULT_RST    = 6'h00;
   localparam logic       LOCK_RST    = 1'b0;
   localparam logic [5:0] INT_CTL_RST = 6'h00;
   localparam logic       MASK_RST    = 1'b0;

   // time base: one step of the multiplier is one 32 Hz period
   localparam longint CLOCK_PERIOD_PS = 64'd4000;
   localparam longint TICK_PERIOD_PS  = 64'd31250000000;
   localparam int     TICK_CYCLES     = int'(TICK_PERIOD_PS / CLOCK_PERIOD_PS);

endpackage : wdt_pkg

/* File: inc/wdt_if.sv */
/*
 * Carrier between the register side and the watchdog counter.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/1ps
interface wdt_if;
   logic       reload;
   logic [5:0] multiplier;
   logic       expire;
   logic [5:0] elapsed;

   modport ctl (output reload, output multiplier, input expire, input elapsed);
   modport cnt (input reload, input multiplier, output expire, output elapsed);
endinterface : wdt_if

/* File: design/wdt_counter.sv */
/*
 * Watchdog counter: 32 Hz tick divider and elapsed-step counter.
 * Assumes reload is a one-cycle pulse and multiplier is stable between writes.
 */
`timescale 1ns/1ps
module wdt_counter #(
   parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // link to the register side
   wdt_if.cnt        wd
);

   localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

   logic [DIV_W-1:0] div;
   logic [5:0]       elapsed;
   logic             expire;
   wire              tick;
   wire              armed;
   wire  [6:0]       next_elapsed;
   wire              reached;

   assign tick         = (div == DIV_LAST);
   assign armed        = (wd.multiplier != 6'h00);
   assign next_elapsed = {1'b0, elapsed} + 7'h01;
   // >= so that lowering the multiplier mid-interval still expires
   assign reached      = (next_elapsed >= {1'b0, wd.multiplier});

   always_ff @(posedge clock)
   begin
      if (srst || wd.reload)
         div <= '0;
      else if (tick)
         div <= '0;
      else
         div <= div + DIV_W'(1);
   end

   always_ff @(posedge clock)
   begin
      if (srst || wd.reload || !armed)
         elapsed <= 6'h00;
      else if (tick)
         elapsed <= reached ? 6'h00 : next_elapsed[5:0];
   end

   always_ff @(posedge clock)
   begin
      if (srst || wd.reload)
         expire <= 1'b0;
      else
         expire <= tick && armed && reached;
   end

   assign wd.expire  = expire;
   assign wd.elapsed = elapsed;

   AST_ZERO_NEVER_EXPIRES: assert property (@(posedge clock) disable iff (srst)
      (wd.multiplier == 6'h00) [*2] |-> !expire)
      else $error("watchdog expired while disabled");

   AST_RELOAD_RESTARTS: assert property (@(posedge clock) disable iff (srst)
      wd.reload |=> (div == '0) && (elapsed == 6'h00) && !expire)
      else $error("reload did not restart the interval");

   AST_EXPIRE_AT_COUNT: assert property (@(posedge clock) disable iff (srst)
      expire |-> ($past(elapsed) + 6'h01 >= $past(wd.multiplier)) && (elapsed == 6'h00))
      else $error("expiry before the programmed step count");

endmodule : wdt_counter

/* File: bench/apb_host.sv */
/*
 * Host software model: APB master issuing one word per register.
 * Assumes a slave on the same clock; waits for pready with no fixed cycle count.
 */
`timescale 1ns/1ps
module apb_host (
   // clock
   input  wire logic        clock,
   // apb master
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [18:0] paddr,
   output      logic [31:0] pwdata,
   output      logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 19'h00000;
      pwdata  = 32'h00000000;
      pstrb   = 4'hf;
   end

   // request held until pready is seen; wait bounded by the bench timeout
   task automatic xfer(input logic wr, input logic [16:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
   begin
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   end
   endtask : xfer
endmodule : apb_host

/* File: bench/tb_top.sv */
/*
 * Self-checking bench for the watchdog register block.
 * Assumes a pull-up on the interrupt pin; tick shortened to 8 cycles.
 */
`timescale 1ns/1ps
module tb_top;
   localparam int T = 8;
   logic        clock = 1'b0;
   logic        srst  = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq, int_out, int_oe, err;
   logic [18:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   int          errors = 0;
   int          n_compared = 0;
   int          cycles = 0;
   // open drain released pin floats high through the pull-up
   wire         int_pin = int_oe ? int_out : 1'b1;

   always #2 clock = ~clock;

   rtc_watchdog_timer #(.TICK_CYCLES(T)) i_dut (.clock(clock), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .int_out(int_out),
      .int_oe(int_oe));
   apb_host i_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   task automatic end_of_test;
   begin
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask : check

   task automatic wr(input logic [16:0] idx, input logic [31:0] d);
   begin
      i_host.xfer(1'b1, idx, d, rd, err);
   end
   endtask : wr

   task automatic rdc(input logic [16:0] idx, input logic [31:0] exp);
   begin
      i_host.xfer(1'b0, idx, 32'h0, rd, err);
      check(rd, exp);
   end
   endtask : rdc

   task automatic flag(input logic exp);
   begin
      i_host.xfer(1'b0, wdt_pkg::IDX_STATUS, 32'h0, rd, err);
      check({31'h0, rd[0]}, {31'h0, exp});
   end
   endtask : flag

   // restrobe before expiry must push the timeout out again
   task automatic check_interval(input logic [5:0] m);
      int w;
   begin
      w = (m * T * 3) / 4 - 4;
      wr(wdt_pkg::IDX_WDOG, {24'h0, 2'b10, m});
      wr(wdt_pkg::IDX_STATUS, 32'h1);
      repeat (w) @(posedge clock);
      flag(1'b0);
      wr(wdt_pkg::IDX_WDOG, {24'h0, 2'b10, m});
      // short settings expire before the restrobe lands; drop that old flag
      wr(wdt_pkg::IDX_STATUS, 32'h1);
      repeat (w) @(posedge clock);
      flag(1'b0);
      repeat (m * T + 10) @(posedge clock);
      flag(1'b1);
   end
   endtask : check_interval

   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         errors++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      rdc(wdt_pkg::IDX_INT_CTL, 32'h0);
      rdc(wdt_pkg::IDX_WDOG, 32'h0);
      rdc(wdt_pkg::IDX_STATUS, 32'h0);
      rdc(wdt_pkg::IDX_MASK, 32'h0);
      wr(wdt_pkg::IDX_WDOG, 32'h43);
      rdc(wdt_pkg::IDX_WDOG, 32'h43);
      wr(wdt_pkg::IDX_WDOG, 32'h85);
      rdc(wdt_pkg::IDX_WDOG, 32'h03);
      i_host.xfer(1'b0, 17'h1fff2, 32'h0, rd, err);
      check({rd[31:1], err}, 32'h1);
      check_interval(6'h01);
      check_interval(6'h3f);
      check({30'h0, int_oe, int_pin}, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr(wdt_pkg::IDX_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check({31'h0, irq}, 32'h1);
      wr(wdt_pkg::IDX_INT_CTL, 32'h80);
      wr(wdt_pkg::IDX_STATUS, 32'h1);
      repeat (63 * T + 10) @(posedge clock);
      flag(1'b1);
      check({30'h0, int_oe, int_pin}, 32'h2);
      wr(wdt_pkg::IDX_INT_CTL, 32'h88);
      repeat (3) @(posedge clock);
      check({30'h0, int_oe, int_out}, 32'h3);
      rdc(wdt_pkg::IDX_INT_CTL, 32'h88);
      wr(wdt_pkg::IDX_WDOG, 32'h00);
      wr(wdt_pkg::IDX_STATUS, 32'h1);
      repeat (3) @(posedge clock);
      check({30'h0, irq, int_out}, 32'h0);
      repeat (70 * T) @(posedge clock);
      rdc(wdt_pkg::IDX_STATUS, 32'h0);
      end_of_test();
   end
endmodule : tb_top
